// ### line_station.sv
// remote station: free running shift clock and line sampler
`timescale 1ns/1ps

module line_station
(
    input wire logic i_line,
    output logic o_shift_clock,
    output logic [7:0] o_word,
    output logic [15:0] o_frames,
    output logic [15:0] o_nbits,
    output logic [15:0] o_raw
);
    int cnt;
    logic [7:0] sh;

    // ==========================================
    // shift clock, unrelated phase
    initial
    begin
        o_shift_clock = 1'b0;
        #7;
        forever #30 o_shift_clock = ~o_shift_clock;
    end

    // ==========================================
    // mid bit sampling, async framing
    initial
    begin
        o_word = 8'h00;
        o_frames = 16'h0000;
        o_nbits = 16'h0000;
        o_raw = 16'h0000;
        cnt = 0;
        sh = 8'h00;
    end

    always @(negedge o_shift_clock)
    begin
        o_raw = {i_line, o_raw[15:1]};
        o_nbits = o_nbits + 16'h0001;
        if (cnt == 0)
        begin
            if (i_line == 1'b0)
                cnt = 1;
        end
        else if (cnt <= 8)
        begin
            sh = {i_line, sh[7:1]};
            cnt = cnt + 1;
        end
        else
        begin
            if (i_line == 1'b1)
            begin
                o_word = sh;
                o_frames = o_frames + 16'h0001;
            end
            cnt = 0;
        end
    end
endmodule

// ### testbench.sv
// register level tests of the usart transmitter
`timescale 1ns/1ps
`include "usart_tx_defines.svh"

module testbench;
    logic i_clock;
    logic i_rst_b;
    logic [`TXS_ADDR_W-1:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    logic o_txd, o_txd_oe, o_loop_en, o_loop_rx_data, o_rx_enable_pulse, o_buf_empty_irq, o_tx_error_irq;
    logic shift_clock;
    logic [7:0] word;
    logic [15:0] frames, nbits, raw, t;
    wire line = o_txd_oe ? o_txd : 1'b1;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    int evt[5] = '{default: 0};
    int e0, k;
    bit found;
    logic [7:0] ctrl_v[3] = '{8'hff, 8'h18, 8'h02};
    logic [7:0] sync_v[3] = '{8'h3f, 8'h1f, 8'hff};

    usart_tx i_usart_tx (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_clock_pin(shift_clock), .o_txd(o_txd),
        .o_txd_oe(o_txd_oe), .o_loop_en(o_loop_en), .o_loop_rx_data(o_loop_rx_data), .o_loop_rx_clock(),
        .o_rx_enable_pulse(o_rx_enable_pulse), .o_buf_empty_irq(o_buf_empty_irq), .o_tx_error_irq(o_tx_error_irq));
    line_station i_line_station (.i_line(line), .o_shift_clock(shift_clock), .o_word(word),
        .o_frames(frames), .o_nbits(nbits), .o_raw(raw));

    // ==========================================
    // clock, event counters, timeout
    initial
    begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    always @(posedge i_clock)
    begin
        cycles++;
        if (o_buf_empty_irq) evt[0] <= evt[0] + 1;
        if (o_tx_error_irq) evt[1] <= evt[1] + 1;
        if (o_rx_enable_pulse) evt[2] <= evt[2] + 1;
        evt[3] <= int'(frames);
        evt[4] <= int'(nbits);
        if (cycles == 60000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    // ==========================================
    // bus tasks and checks
    task end_of_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task rdc(input logic [3:0] a, input logic [7:0] exp, input string name);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 check(name, {8'h00, o_rdata}, {8'h00, exp});
        @(posedge i_clock);
    endtask

    task wait_evt(input int idx, input int v);
        int n;
        n = 0;
        while (evt[idx] < v && n < 5000)
        begin
            @(posedge i_clock);
            n++;
        end
        check("event count reached", 16'(evt[idx] >= v), 16'h0001);
    endtask

    // ==========================================
    // test sequence
    initial
    begin
        i_rst_b = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        rdc(`TXS_OFS_STAT, 8'h80, "status reset");
        rdc(`TXS_OFS_CTRL, 8'h01, "control reset");
        rdc(`TXS_OFS_SYNC, 8'h00, "sync reset");
        wr(4'h3, 8'hff);
        rdc(4'h3, 8'h00, "unmapped read");
        for (k = 0; k < 4; k++)
        begin
            wr(`TXS_OFS_STAT, 8'(k << 1));
            repeat (2) @(posedge i_clock);
            #1 check("idle enable", {15'h0000, o_txd_oe}, 16'(k != 0));
            check("idle level", {15'h0000, o_txd}, 16'(k >= 2));
            check("loop select", {15'h0000, o_loop_en}, 16'(k == 3));
            check("loop data", {15'h0000, o_loop_rx_data}, 16'h0001);
            @(posedge i_clock);
        end
        for (k = 0; k < 3; k++)
        begin
            wr(`TXS_OFS_CTRL, ctrl_v[k]);
            wr(`TXS_OFS_SYNC, 8'hff);
            rdc(`TXS_OFS_SYNC, sync_v[k], "sync mask");
        end
        rdc(`TXS_OFS_CTRL, 8'h02, "control readback");
        wr(`TXS_OFS_CTRL, 8'h01);
        // async words back to back, then underrun
        wr(`TXS_OFS_DATA, 8'ha5);
        rdc(`TXS_OFS_STAT, 8'h06, "loaded while off");
        wr(`TXS_OFS_STAT, 8'h05);
        rdc(`TXS_OFS_STAT, 8'h05, "enabled");
        wait_evt(0, 1);
        wr(`TXS_OFS_DATA, 8'h3c);
        rdc(`TXS_OFS_STAT, 8'h05, "reloaded");
        wait_evt(0, 2);
        e0 = evt[1];
        wait_evt(1, e0 + 1);
        check("frames", frames, 16'h0002);
        check("last word", {8'h00, word}, 16'h003c);
        rdc(`TXS_OFS_STAT, 8'hc5, "underrun");
        rdc(`TXS_OFS_STAT, 8'h85, "underrun read clear");
        // disable in mid word with auto turnaround
        wr(`TXS_OFS_DATA, 8'h5a);
        wait_evt(0, 3);
        wr(`TXS_OFS_STAT, 8'h24);
        wait_evt(2, 1);
        check("final word", {8'h00, word}, 16'h005a);
        rdc(`TXS_OFS_STAT, 8'hb4, "done no underrun");
        // break with a word loaded during it
        wr(`TXS_OFS_STAT, 8'h0d);
        e0 = evt[1];
        wait_evt(1, e0 + 2);
        wr(`TXS_OFS_DATA, 8'h81);
        rdc(`TXS_OFS_STAT, 8'h0d, "break holds buffer");
        wr(`TXS_OFS_STAT, 8'h05);
        wait_evt(3, 4);
        check("word after break", {8'h00, word}, 16'h0081);
        e0 = evt[1];
        wait_evt(1, e0 + 1);
        wr(`TXS_OFS_STAT, 8'h04);
        wait_evt(1, e0 + 2);
        rdc(`TXS_OFS_STAT, 8'h94, "disabled done");
        // sync format fill with the sync character
        wr(`TXS_OFS_CTRL, 8'h00);
        wr(`TXS_OFS_SYNC, 8'h7e);
        wr(`TXS_OFS_DATA, 8'h3c);
        wr(`TXS_OFS_STAT, 8'h05);
        e0 = evt[1];
        wait_evt(1, e0 + 1);
        wait_evt(4, evt[4] + 24);
        found = 1'b0;
        for (k = 0; k < 8; k++)
        begin
            t = {8'h7e, 8'h7e} >> k;
            if (t[7:0] === raw[7:0]) found = 1'b1;
        end
        check("fill repeats", raw[15:8], {8'h00, raw[7:0]} & 16'h00ff);
        check("fill is sync char", {15'h0000, found}, 16'h0001);
        end_of_test();
    end
endmodule

// ### tx_status_checker.sv
// assertion checker for the transmitter register and event ports
`timescale 1ns/1ps
`include "usart_tx_defines.svh"

module tx_status_checker
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [`TXS_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_loop_en,
    input wire logic o_rx_enable_pulse,
    input wire logic o_buf_empty_irq,
    input wire logic o_tx_error_irq
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    // ==========================================
    // register port
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    AST_UNMAPPED_READ: assert property ($past(i_rd && i_addr < `TXS_OFS_CTRL) |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_STATUS_READBACK: assert property ((i_wr && i_addr == `TXS_OFS_STAT) ##1 (i_rd && i_addr == `TXS_OFS_STAT)
        |=> o_rdata[5] == $past(i_wdata[5], 2) && o_rdata[3:0] == $past(i_wdata[3:0], 2))
        else $error("status control bits not read back");
    AST_DONE_CLEARED: assert property ((i_wr && i_addr == `TXS_OFS_STAT && i_wdata[0])
        ##1 (i_rd && i_addr == `TXS_OFS_STAT) |=> !o_rdata[4])
        else $error("done flag not cleared by enable");

    // ==========================================
    // idle select and loopback
    AST_LOOP_ON: assert property ((i_wr && i_addr == `TXS_OFS_STAT && i_wdata[2:1] == 2'b11) |-> ##[1:2] o_loop_en)
        else $error("loopback not entered");
    AST_LOOP_OFF: assert property ((i_wr && i_addr == `TXS_OFS_STAT && i_wdata[2:1] != 2'b11) |-> ##[1:2] !o_loop_en)
        else $error("loopback not left");

    // ==========================================
    // event pulses
    AST_BE_IRQ_EDGE: assert property (o_buf_empty_irq |=> !o_buf_empty_irq)
        else $error("buffer empty event longer than one cycle");
    AST_ERR_IRQ_EDGE: assert property (o_tx_error_irq |=> !o_tx_error_irq)
        else $error("error event longer than one cycle");
    AST_RXEN_PULSE: assert property (o_rx_enable_pulse |=> !o_rx_enable_pulse)
        else $error("receiver enable pulse longer than one cycle");
endmodule

bind usart_tx tx_status_checker i_tx_status_checker (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_loop_en(o_loop_en),
    .o_rx_enable_pulse(o_rx_enable_pulse),
    .o_buf_empty_irq(o_buf_empty_irq),
    .o_tx_error_irq(o_tx_error_irq)
);

// ### usart_tx.sv
// usart transmitter with status/control, async format break, idle select and loopback
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "usart_tx_defines.svh"

module usart_tx
    import usart_tx_pkg::*;
#(
    parameter int FRAME_W = 12
)
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [`TXS_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_tx_clock_pin,
    output logic o_txd,
    output logic o_txd_oe,
    output logic o_loop_en,
    output logic o_loop_rx_data,
    output logic o_loop_rx_clock,
    output logic o_rx_enable_pulse,
    output logic o_buf_empty_irq,
    output logic o_tx_error_irq
);

    // ==========================================================
    // parameter check
    generate
        if (FRAME_W < 11)
        begin : g_frame_chk
            $error("FRAME_W too small for longest frame");
        end
    endgenerate

    // ==========================================================
    // state
    ctrl_t ctrl_q;
    stat_t stat_q;
    tx_state_t state_q;
    frame_kind_t kind_q;
    frame_kind_t next_kind;
    logic [7:0] sync_q;
    logic [7:0] usart_data_reg_q;
    logic buf_full_q;
    logic lead_q;
    logic armed_q;
    logic line_q;
    logic [FRAME_W-1:0] shift_q;
    logic [3:0] cnt_q;
    logic tc_s1_q;
    logic tc_s2_q;
    logic tc_s3_q;
    logic tc_lvl_q;
    logic be_prev_q;
    logic ue_prev_q;
    logic done_prev_q;
    logic brk_evt_q;
    logic [3:0] wl;
    logic brk_eff;
    logic tick;
    logic boundary;
    logic stop_evt;
    logic take_data;
    logic starve_evt;
    logic wr_stat;
    logic wr_data;
    logic xe_rise;
    logic [FRAME_W-1:0] frame_d;
    logic [3:0] len_d;

    assign wl = `TXS_WORD_MAX - {2'b00, ctrl_q.wl_code};
    assign brk_eff = stat_q.brk & ctrl_q.async_fmt;
    assign wr_stat = i_wr & (i_addr == `TXS_OFS_STAT);
    assign wr_data = i_wr & (i_addr == `TXS_OFS_DATA);
    assign xe_rise = wr_stat & i_wdata[`TXS_STAT_XE] & ~stat_q.xe;

    // ==========================================================
    // shift clock pin synchroniser
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            tc_s1_q <= 1'b0;
            tc_s2_q <= 1'b0;
            tc_s3_q <= 1'b0;
            tc_lvl_q <= 1'b0;
        end
        else
        begin
            tc_s1_q <= i_tx_clock_pin;
            tc_s2_q <= tc_s1_q;
            tc_s3_q <= tc_s2_q;
            if (tc_s2_q == tc_s3_q)
            begin
                tc_lvl_q <= tc_s3_q;
            end
        end
    end

    assign tick = (tc_s2_q == tc_s3_q) & tc_s3_q & ~tc_lvl_q;
    assign boundary = tick & (state_q == TX_RUN) & (cnt_q <= 4'd1);
    assign stop_evt = boundary & ~stat_q.xe;

    // ==========================================================
    // next character choice
    always_comb
    begin
        next_kind = FK_NONE;
        if (stat_q.xe)
        begin
            if (lead_q || (kind_q == FK_BREAK && !brk_eff))
            begin
                next_kind = FK_LEAD;
            end
            else if (brk_eff)
            begin
                next_kind = FK_BREAK;
            end
            else if (buf_full_q)
            begin
                next_kind = FK_DATA;
            end
            else if (!ctrl_q.async_fmt)
            begin
                next_kind = FK_SYNC;
            end
        end
    end

    assign take_data = boundary & (next_kind == FK_DATA);
    assign starve_evt = boundary & stat_q.xe & armed_q & ((next_kind == FK_SYNC) | (next_kind == FK_NONE));

    // ==========================================================
    // frame assembly
    always_comb
    begin
        logic [7:0] word;
        logic [7:0] mask;
        logic par;
        word = 8'h00;
        mask = 8'hff >> (4'd8 - wl);
        par = 1'b0;
        frame_d = '0;
        len_d = wl + {3'b000, ctrl_q.par_en} + (ctrl_q.async_fmt ? 4'd2 : 4'd0);
        if (next_kind == FK_LEAD)
        begin
            frame_d[0] = 1'b1;
            len_d = 4'd1;
        end
        else if (next_kind == FK_DATA || next_kind == FK_SYNC)
        begin
            word = (next_kind == FK_SYNC) ? sync_q : usart_data_reg_q;
            frame_d[7:0] = word & mask;
            par = (^(word & mask)) ^ ~ctrl_q.par_even;
            // sync parity from stored bit below eight
            if (next_kind == FK_SYNC && wl != `TXS_WORD_MAX)
            begin
                par = word[wl[2:0]];
            end
            if (ctrl_q.par_en)
            begin
                frame_d[wl] = par;
            end
            if (ctrl_q.async_fmt)
            begin
                frame_d[wl + {3'b000, ctrl_q.par_en}] = 1'b1;
                frame_d = frame_d << 1;
            end
        end
    end

    // ==========================================================
    // shift engine
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            state_q <= TX_OFF;
            kind_q <= FK_NONE;
            shift_q <= '0;
            cnt_q <= 4'd0;
            line_q <= 1'b1;
        end
        else if (state_q == TX_OFF)
        begin
            line_q <= 1'b1;
            cnt_q <= 4'd0;
            kind_q <= FK_NONE;
            if (stat_q.xe)
            begin
                state_q <= TX_RUN;
            end
        end
        else if (tick && cnt_q > 4'd1)
        begin
            shift_q <= shift_q >> 1;
            line_q <= shift_q[1];
            cnt_q <= cnt_q - 4'd1;
        end
        else if (boundary)
        begin
            if (!stat_q.xe)
            begin
                state_q <= TX_OFF;
                cnt_q <= 4'd0;
                line_q <= 1'b1;
                kind_q <= FK_NONE;
            end
            else if (next_kind == FK_NONE)
            begin
                cnt_q <= 4'd0;
                line_q <= 1'b1;
                kind_q <= FK_NONE;
            end
            else
            begin
                shift_q <= frame_d;
                line_q <= frame_d[0];
                cnt_q <= len_d;
                kind_q <= next_kind;
            end
        end
    end

    // ==========================================================
    // lead bit and underrun arming
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            lead_q <= 1'b0;
            armed_q <= 1'b0;
        end
        else
        begin
            if (xe_rise)
            begin
                lead_q <= 1'b1;
            end
            else if (boundary && next_kind == FK_LEAD)
            begin
                lead_q <= 1'b0;
            end
            if (!stat_q.xe || starve_evt)
            begin
                armed_q <= 1'b0;
            end
            else if (boundary && (next_kind == FK_DATA || next_kind == FK_BREAK))
            begin
                armed_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // transmit buffer
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            usart_data_reg_q <= `TXS_DATA_RST;
            buf_full_q <= 1'b0;
        end
        else if (wr_data)
        begin
            usart_data_reg_q <= i_wdata;
            buf_full_q <= 1'b1;
        end
        else if (take_data)
        begin
            buf_full_q <= 1'b0;
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            ctrl_q <= `TXS_CTRL_RST;
            sync_q <= `TXS_SYNC_RST;
        end
        else if (i_wr && i_addr == `TXS_OFS_CTRL)
        begin
            ctrl_q <= {3'b000, i_wdata[`TXS_CTRL_WL_HI:0]};
        end
        else if (i_wr && i_addr == `TXS_OFS_SYNC)
        begin
            sync_q <= i_wdata & (8'hff >> (4'd8 - wl - {3'b000, ctrl_q.par_en & (wl != `TXS_WORD_MAX)}));
        end
    end

    // ==========================================================
    // status and control bits
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            stat_q <= '0;
            stat_q.be <= 1'b1;
        end
        else
        begin
            if (wr_stat)
            begin
                stat_q.at <= i_wdata[`TXS_STAT_AT];
                stat_q.brk <= i_wdata[`TXS_STAT_BRK];
                stat_q.hi <= i_wdata[`TXS_STAT_HI];
                stat_q.lo <= i_wdata[`TXS_STAT_LO];
                stat_q.xe <= i_wdata[`TXS_STAT_XE];
            end
            if (wr_data)
            begin
                stat_q.be <= 1'b0;
            end
            else if (take_data)
            begin
                stat_q.be <= 1'b1;
            end
            if (starve_evt)
            begin
                stat_q.starved <= 1'b1;
            end
            else if ((i_rd && i_addr == `TXS_OFS_STAT) || !stat_q.xe)
            begin
                stat_q.starved <= 1'b0;
            end
            if (stop_evt)
            begin
                stat_q.done <= 1'b1;
            end
            else if (xe_rise)
            begin
                stat_q.done <= 1'b0;
            end
        end
    end

    // ==========================================================
    // register read port
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_rd)
        begin
            unique case (i_addr)
                `TXS_OFS_STAT: o_rdata <= stat_q;
                `TXS_OFS_CTRL: o_rdata <= ctrl_q;
                `TXS_OFS_SYNC: o_rdata <= sync_q;
                `TXS_OFS_DATA: o_rdata <= usart_data_reg_q;
                default: o_rdata <= 8'h00;
            endcase
        end
        else
        begin
            o_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // line output, idle select and loopback
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            o_txd <= 1'b0;
            o_txd_oe <= 1'b0;
            o_loop_en <= 1'b0;
            o_loop_rx_data <= 1'b1;
            o_loop_rx_clock <= 1'b0;
        end
        else
        begin
            o_loop_en <= stat_q.hi & stat_q.lo;
            o_loop_rx_data <= (state_q == TX_RUN) ? line_q : 1'b1;
            o_loop_rx_clock <= tc_lvl_q;
            if (state_q == TX_RUN)
            begin
                o_txd <= line_q;
                o_txd_oe <= 1'b1;
            end
            else
            begin
                o_txd <= stat_q.hi;
                o_txd_oe <= stat_q.hi | stat_q.lo;
            end
        end
    end

    // ==========================================================
    // interrupt channels and turnaround
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            be_prev_q <= 1'b1;
            ue_prev_q <= 1'b0;
            done_prev_q <= 1'b0;
            brk_evt_q <= 1'b0;
            o_buf_empty_irq <= 1'b0;
            o_tx_error_irq <= 1'b0;
            o_rx_enable_pulse <= 1'b0;
        end
        else
        begin
            be_prev_q <= stat_q.be;
            ue_prev_q <= stat_q.starved;
            done_prev_q <= stat_q.done;
            brk_evt_q <= boundary & (kind_q == FK_BREAK);
            o_buf_empty_irq <= stat_q.be & ~be_prev_q;
            o_tx_error_irq <= (stat_q.starved & ~ue_prev_q) | (stat_q.done & ~done_prev_q) | brk_evt_q;
            o_rx_enable_pulse <= stop_evt & stat_q.at;
        end
    end

endmodule

// ### usart_tx_defines.svh
// offsets, field positions, reset values of the transmitter
`ifndef USART_TX_DEFINES_SVH
`define USART_TX_DEFINES_SVH
`define TXS_ADDR_W 4
`define TXS_OFS_CTRL 4'hc
`define TXS_OFS_SYNC 4'hd
`define TXS_OFS_STAT 4'he
`define TXS_OFS_DATA 4'hf
`define TXS_STAT_BE 7
`define TXS_STAT_UE 6
`define TXS_STAT_AT 5
`define TXS_STAT_END 4
`define TXS_STAT_BRK 3
`define TXS_STAT_HI 2
`define TXS_STAT_LO 1
`define TXS_STAT_XE 0
`define TXS_CTRL_ASYNC 0
`define TXS_CTRL_PAR_EN 1
`define TXS_CTRL_PAR_EVEN 2
`define TXS_CTRL_WL_LO 3
`define TXS_CTRL_WL_HI 4
`define TXS_CTRL_RST 8'h01
`define TXS_SYNC_RST 8'h00
`define TXS_DATA_RST 8'h00
`define TXS_WORD_MAX 4'h8
`endif

// ### usart_tx_pkg.sv
// types shared by the transmitter design
package usart_tx_pkg;
    typedef enum {TX_OFF, TX_RUN} tx_state_t;
    typedef enum {FK_NONE, FK_LEAD, FK_DATA, FK_SYNC, FK_BREAK} frame_kind_t;
    typedef struct packed {
        logic [2:0] rsvd;
        logic [1:0] wl_code;
        logic par_even;
        logic par_en;
        logic async_fmt;
    } ctrl_t;
    typedef struct packed {
        logic be;
        logic starved;
        logic at;
        logic done;
        logic brk;
        logic hi;
        logic lo;
        logic xe;
    } stat_t;
endpackage
